// file: inc/three_wire_pkg.sv
package three_wire_pkg;
    localparam logic [15:0] ADDR_ASYNC_MODE = 16'hff70;
    localparam logic [15:0] ADDR_SYNC_MODE = 16'hff72;
    localparam logic [15:0] ADDR_BAUD_SEL = 16'hff73;
    localparam logic [15:0] ADDR_SHIFT_IO = 16'hff74;
    localparam logic [7:0] ASYNC_MODE_RESET = 8'h00;
    localparam logic [7:0] SYNC_MODE_RESET = 8'h00;
    localparam logic [7:0] BAUD_SEL_RESET = 8'h00;
    localparam logic [7:0] ASYNC_MODE_MASK = 8'hfc;
    localparam logic [7:0] SYNC_MODE_MASK = 8'h86;
    localparam logic [7:0] BAUD_SEL_MASK = 8'hf0;
    localparam int BIT_TX_ENABLE = 7;
    localparam int BIT_RX_ENABLE = 6;
    localparam int BIT_PARITY_HI = 5;
    localparam int BIT_PARITY_LO = 4;
    localparam int BIT_CHAR_LEN = 3;
    localparam int BIT_STOP_LEN = 2;
    localparam int BIT_THREE_WIRE_EN = 7;
    localparam int BIT_ORDER = 2;
    localparam int BIT_CLK_SRC = 1;
    localparam int SRC_CODE_LSB = 4;
    localparam logic [3:0] SRC_CODE_MAX = 4'h7;
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [3:0] CHAR_BITS_SHORT = 4'h7;
    localparam logic [3:0] CHAR_BITS_LONG = 4'h8;
    localparam logic [1:0] STOP_BITS_ONE = 2'h1;
    localparam logic [1:0] STOP_BITS_TWO = 2'h2;
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ZERO = 2'h1,
        PAR_ODD = 2'h2,
        PAR_EVEN = 2'h3
    } parity_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOW = 2'h1,
        ST_HIGH = 2'h3
    } shift_state_e;
endpackage

// file: inc/baud_if.sv
`timescale 1ns/1ps
interface baud_if;
    logic run;
    logic [3:0] code;
    logic tick;
    modport ctrl (output run, output code, input tick);
    modport gen (input run, input code, output tick);
endinterface

// file: core/baud_divider.sv
`timescale 1ns/1ps
module baud_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    baud_if.gen bus
);
    logic [8:0] count_r;
    logic [8:0] limit;

    // One tick per half shift clock: a half period is 2^n cycles of fx, n = code + 1.
    assign limit = 9'((9'h1 << (bus.code + 4'h1)) - 9'h1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= 9'h000;
        end else if (!bus.run || bus.tick) begin
            count_r <= 9'h000;
        end else begin
            count_r <= count_r + 9'h001;
        end
    end

    assign bus.tick = bus.run && (count_r == limit);

    chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.tick |-> $past(count_r) == limit - 9'h1 || limit == 9'h1)
        else $error("divider tick spacing wrong");
endmodule

// file: core/three_wire_serial_io.sv
`timescale 1ns/1ps
module three_wire_serial_io (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic sck_in_i,
    output logic sck_out_o,
    output logic sck_oe_n_o,
    output logic so_o,
    input wire logic si_i,
    output logic transfer_done_irq_o,
    output logic [1:0] parity_mode_o,
    output logic [3:0] char_bits_o,
    output logic [1:0] stop_bits_o
);
    logic [7:0] async_mode_control_r;
    logic [7:0] sync_mode_control_r;
    logic [7:0] baud_source_select_r;
    logic [7:0] shift_io_reg_r;
    logic [7:0] receive_buffer_reg_r;
    logic [3:0] bit_count_r;
    logic so_latch_r;
    logic sck_int_r;
    logic sck_ext_r;
    logic done_r;
    three_wire_pkg::shift_state_e state_r;
    logic three_wire_enable;
    logic bit_order_select;
    logic clock_source_select;
    logic shift_wr;
    logic can_start;
    logic start;
    logic fall_edge;
    logic rise_edge;
    logic active;
    logic last_bit;
    logic [7:0] rdata_r;

    baud_if baud ();
    baud_divider u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(baud)
    );

    function automatic logic [7:0] reg_write(input logic [7:0] data, input logic [7:0] mask);
        reg_write = data & mask;
    endfunction

    assign three_wire_enable = sync_mode_control_r[three_wire_pkg::BIT_THREE_WIRE_EN];
    assign bit_order_select = sync_mode_control_r[three_wire_pkg::BIT_ORDER];
    assign clock_source_select = sync_mode_control_r[three_wire_pkg::BIT_CLK_SRC];
    assign shift_wr = wr_i && (addr_i == three_wire_pkg::ADDR_SHIFT_IO);
    assign active = (state_r != three_wire_pkg::ST_IDLE);

    // Enable is sampled at the write itself, so setting it later starts nothing.
    assign can_start = three_wire_enable && (clock_source_select ? !active : sck_ext_r);
    assign start = shift_wr && can_start && !active;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            async_mode_control_r <= three_wire_pkg::ASYNC_MODE_RESET;
            sync_mode_control_r <= three_wire_pkg::SYNC_MODE_RESET;
            baud_source_select_r <= three_wire_pkg::BAUD_SEL_RESET;
        end else if (wr_i) begin
            unique case (addr_i)
                three_wire_pkg::ADDR_ASYNC_MODE: begin
                    // Bits 1:0 are forced to zero on every write.
                    async_mode_control_r <= reg_write(wdata_i, three_wire_pkg::ASYNC_MODE_MASK);
                end
                three_wire_pkg::ADDR_SYNC_MODE: begin
                    sync_mode_control_r <= reg_write(wdata_i, three_wire_pkg::SYNC_MODE_MASK);
                end
                three_wire_pkg::ADDR_BAUD_SEL: begin
                    baud_source_select_r <= reg_write(wdata_i, three_wire_pkg::BAUD_SEL_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // Async decode fields are exported for the UART side of the port.
    assign parity_mode_o = async_mode_control_r[three_wire_pkg::BIT_PARITY_HI:
        three_wire_pkg::BIT_PARITY_LO];
    assign char_bits_o = async_mode_control_r[three_wire_pkg::BIT_CHAR_LEN] ?
        three_wire_pkg::CHAR_BITS_LONG : three_wire_pkg::CHAR_BITS_SHORT;
    assign stop_bits_o = async_mode_control_r[three_wire_pkg::BIT_STOP_LEN] ?
        three_wire_pkg::STOP_BITS_TWO : three_wire_pkg::STOP_BITS_ONE;

    // External clock is only a sampled level; the prescaler plays no part there.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_ext_r <= 1'b1;
        end else begin
            sck_ext_r <= sck_in_i;
        end
    end

    assign baud.run = active && clock_source_select;
    assign baud.code = baud_source_select_r[three_wire_pkg::SRC_CODE_LSB +: 4];

    assign fall_edge = active && (clock_source_select ? (baud.tick && sck_int_r)
        : (sck_ext_r && !sck_in_i));
    assign rise_edge = active && (clock_source_select ? (baud.tick && !sck_int_r)
        : (!sck_ext_r && sck_in_i));
    assign last_bit = (bit_count_r == three_wire_pkg::FRAME_BITS - 4'h1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= three_wire_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                three_wire_pkg::ST_IDLE: begin
                    if (start) begin
                        state_r <= three_wire_pkg::ST_HIGH;
                    end
                end
                three_wire_pkg::ST_HIGH: begin
                    if (fall_edge) begin
                        state_r <= three_wire_pkg::ST_LOW;
                    end
                end
                three_wire_pkg::ST_LOW: begin
                    if (rise_edge && last_bit) begin
                        state_r <= three_wire_pkg::ST_IDLE;
                    end else if (rise_edge) begin
                        state_r <= three_wire_pkg::ST_HIGH;
                    end
                end
                default: begin
                    state_r <= three_wire_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Idle level high, so each frame opens with a falling edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_int_r <= 1'b1;
        end else if (!active || !clock_source_select) begin
            sck_int_r <= 1'b1;
        end else if (baud.tick) begin
            sck_int_r <= !sck_int_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_count_r <= 4'h0;
        end else if (start) begin
            bit_count_r <= 4'h0;
        end else if (rise_edge && !last_bit) begin
            bit_count_r <= bit_count_r + 4'h1;
        end
    end

    // One register serves as both shift directions: transmit bit leaves, received bit enters.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_io_reg_r <= 8'h00;
            so_latch_r <= 1'b1;
        end else if (start) begin
            shift_io_reg_r <= wdata_i;
        end else if (fall_edge) begin
            so_latch_r <= bit_order_select ? shift_io_reg_r[0] : shift_io_reg_r[7];
        end else if (rise_edge) begin
            shift_io_reg_r <= bit_order_select ? {si_i, shift_io_reg_r[7:1]}
                : {shift_io_reg_r[6:0], si_i};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            receive_buffer_reg_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            done_r <= rise_edge && last_bit;
            if (rise_edge && last_bit) begin
                receive_buffer_reg_r <= bit_order_select ? {si_i, shift_io_reg_r[7:1]}
                    : {shift_io_reg_r[6:0], si_i};
            end
        end
    end

    assign transfer_done_irq_o = done_r;
    assign so_o = so_latch_r;
    assign sck_out_o = sck_int_r;
    assign sck_oe_n_o = !clock_source_select;

    // Read data is registered on the strobe, so it stands from the cycle after rd_i is taken.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                three_wire_pkg::ADDR_ASYNC_MODE: rdata_r <= async_mode_control_r;
                three_wire_pkg::ADDR_SYNC_MODE: rdata_r <= sync_mode_control_r;
                three_wire_pkg::ADDR_BAUD_SEL: rdata_r <= baud_source_select_r;
                three_wire_pkg::ADDR_SHIFT_IO: begin
                    rdata_r <= active ? shift_io_reg_r : receive_buffer_reg_r;
                end
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_r;

    sequence frame_end_s;
        rise_edge && last_bit;
    endsequence

    chk_reset_async: assert property (@(posedge clk_i)
        $fell(rst_i) |-> async_mode_control_r == three_wire_pkg::ASYNC_MODE_RESET)
        else $error("async mode not cleared by reset");
    chk_async_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        async_mode_control_r[1:0] == 2'h0)
        else $error("async mode low bits not zero");
    chk_baud_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        baud_source_select_r[3:0] == 4'h0)
        else $error("prescaler low nibble not zero");
    chk_done_after_eight: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_end_s |=> transfer_done_irq_o && !active)
        else $error("frame end did not raise done");
    chk_no_start_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        (shift_wr && !three_wire_enable && !active) |=> !active)
        else $error("transfer started while disabled");
    chk_start_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
        (shift_wr && three_wire_enable && clock_source_select && !active) |=> active)
        else $error("enabled write did not start");
    chk_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !active |-> sck_out_o)
        else $error("internal clock not high when idle");
    chk_parity_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == three_wire_pkg::ADDR_ASYNC_MODE) |=>
        parity_mode_o == $past(wdata_i[5:4]))
        else $error("parity field misplaced");
    chk_ext_no_baud: assert property (@(posedge clk_i) disable iff (rst_i)
        !clock_source_select |-> !baud.run)
        else $error("prescaler runs on external clock");
endmodule

// file: verif/far_end.sv
`timescale 1ns/1ps
module far_end (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic so_i,
    output logic si_o,
    output logic sck_ext_o
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    int rises;
    initial begin
        si_o = 1'b1;
        sck_ext_o = 1'b1;
        tx_r = 8'h00;
        rx_r = 8'h00;
        rises = 0;
    end
    task automatic load(input logic [7:0] v);
        tx_r = v;
        rises = 0;
    endtask
    // The external clock runs only within a frame and rests high between frames.
    task automatic clock_frame(input int half);
        repeat (8) begin
            repeat (half) @(posedge clk_i);
            sck_ext_o <= 1'b0;
            repeat (half) @(posedge clk_i);
            sck_ext_o <= 1'b1;
        end
    endtask
    always @(negedge sck_i) begin
        si_o <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
    end
    always @(posedge sck_i) begin
        rx_r <= {rx_r[6:0], so_i};
        rises = rises + 1;
        if (rises == 8) begin
            // Once the hold time is over the line flips, so a late sample is seen.
            repeat (3) @(posedge clk_i);
            si_o <= ~si_o;
        end
    end
endmodule

// file: verif/test_three_wire_serial_io.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module test_three_wire_serial_io;
    logic clk_i, rst_i, wr_i, rd_i, si_i, sck_ext, sck_w;
    logic sck_out_o, sck_oe_n_o, so_o, transfer_done_irq_o;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v, got;
    logic [1:0] parity_mode_o, stop_bits_o;
    logic [3:0] char_bits_o;
    int fail_count = 0, checks_done = 0, low_cnt = 0, irq_cnt = 0, seed_v;
    assign sck_w = (sck_oe_n_o === 1'b0) ? sck_out_o : sck_ext;
    three_wire_serial_io DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sck_in_i(sck_ext),
        .sck_out_o(sck_out_o), .sck_oe_n_o(sck_oe_n_o), .so_o(so_o), .si_i(si_i),
        .transfer_done_irq_o(transfer_done_irq_o), .parity_mode_o(parity_mode_o),
        .char_bits_o(char_bits_o), .stop_bits_o(stop_bits_o));
    far_end far (.clk_i(clk_i), .sck_i(sck_w), .so_i(so_o), .si_o(si_i), .sck_ext_o(sck_ext));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (sck_out_o === 1'b0) low_cnt++;
        if (transfer_done_irq_o === 1'b1) irq_cnt++;
    end
    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (checks_done > 0 && fail_count == 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic xfer(input logic [3:0] code, input logic lsb, input logic ext);
        logic [7:0] d, p, r;
        int n;
        d = 8'($urandom);
        p = 8'($urandom);
        wr(16'hff73, {code, 4'h0});
        wr(16'hff72, {1'b1, 4'h0, lsb, ~ext, 1'b0});
        far.load(p);
        low_cnt = 0;
        irq_cnt = 0;
        wr(16'hff74, d);
        if (ext) far.clock_frame(3);
        n = 0;
        while (irq_cnt == 0 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (4) @(posedge clk_i);
        `CHK(irq_cnt, 1)
        `CHK(far.rx_r, lsb ? rev8(d) : d)
        rd(16'hff74, r);
        `CHK(r, lsb ? rev8(p) : p)
        `CHK(low_cnt, ext ? 0 : (8 << (code + 1)))
        `CHK(sck_oe_n_o, ext)
        `CHK(sck_out_o, 1'b1)
        $display("test transfer code %0d lsb %0d ext %0d done", code, lsb, ext);
    endtask
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        rst_i = 1'b1;
        addr_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        wdata_i = 8'h00;
        seed_v = $urandom(76);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(16'hff70, got);
        `CHK(got, 8'h00)
        rd(16'hff72, got);
        `CHK(got, 8'h00)
        rd(16'hff73, got);
        `CHK(got, 8'h00)
        `CHK(sck_out_o, 1'b1)
        `CHK(so_o, 1'b1)
        `CHK(transfer_done_irq_o, 1'b0)
        `CHK(sck_oe_n_o, 1'b1)
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], i[3:0]};
            wr(16'hff70, v);
            rd(16'hff70, got);
            `CHK(got, v & 8'hfc)
            `CHK(parity_mode_o, v[5:4])
            `CHK(char_bits_o, v[3] ? 4'h8 : 4'h7)
            `CHK(stop_bits_o, v[2] ? 2'h2 : 2'h1)
        end
        wr(16'hff70, 8'h00);
        v = 8'($urandom);
        wr(16'hff73, v);
        rd(16'hff73, got);
        `CHK(got, v & 8'hf0)
        rd(16'hff7f, got);
        `CHK(got, 8'h00)
        $display("test registers done");
        wr(16'hff72, 8'h02);
        low_cnt = 0;
        irq_cnt = 0;
        wr(16'hff74, 8'h5a);
        wr(16'hff72, 8'h82);
        repeat (300) @(posedge clk_i);
        `CHK(irq_cnt, 0)
        `CHK(low_cnt, 0)
        $display("test late enable done");
        // The simulated clock is not the slow rated one, so code 0 is allowed here.
        for (int c = 0; c < 8; c++) xfer(c[3:0], 1'($urandom), 1'b0);
        repeat (2) xfer(4'($urandom_range(7)), 1'($urandom), 1'b1);
        tally_and_finish;
    end
endmodule
